// ---- design/ciw_pkg.sv ----
package ciw_pkg;

   typedef enum logic [2:0] {
      MODE_NORMAL   = 3'h0,
      MODE_DISABLE  = 3'h1,
      MODE_LOOPBACK = 3'h2,
      MODE_LISTEN   = 3'h3,
      MODE_CONFIG   = 3'h4,
      MODE_LISTALL  = 3'h7
   } ciw_mode_type;

   typedef enum logic [2:0] {
      ST_RUN    = 3'b001,
      ST_HALT   = 3'b010,
      ST_SETTLE = 3'b100
   } ciw_wake_state_type;

endpackage : ciw_pkg

// ---- design/ciw_regs.svh ----
`ifndef CIW_REGS_SVH
`define CIW_REGS_SVH

// register byte offsets on the apb
`define CIW_CTRL_OFS        12'h000
`define CIW_FLAG_OFS        12'h004
`define CIW_ENABLE_OFS      12'h008
`define CIW_CFG2_OFS        12'h00C

// module_control_reg field positions
`define CIW_CTRL_TIMESTAMP_ENABLE_BIT 15
`define CIW_CTRL_SIDL_BIT   13
`define CIW_CTRL_REQ_HI     10
`define CIW_CTRL_REQ_LO     8
`define CIW_CTRL_CUR_HI     7
`define CIW_CTRL_CUR_LO     5
`define CIW_CTRL_CODE_HI    3
`define CIW_CTRL_CODE_LO    1

// irq_flag_reg / irq_enable_reg bit positions
`define CIW_RX0_BIT         0
`define CIW_RX1_BIT         1
`define CIW_TX0_BIT         2
`define CIW_TX1_BIT         3
`define CIW_TX2_BIT         4
`define CIW_ERR_BIT         5
`define CIW_WAK_BIT         6
`define CIW_IVR_BIT         7
`define CIW_ESRC_LO         8
`define CIW_FLAG_W          15
`define CIW_MAIN_W          8
`define CIW_ESRC_W          7

// error sources 2..6 come from error counter thresholds
`define CIW_ESRC_EXEMPT     7'h7C

// timing_config_two_reg
`define CIW_CFG2_WAKE_GLITCH_FILTER_ENABLE_BIT 14
`define CIW_CFG2_MASK       16'h47FF

// reset values
`define CIW_CTRL_RST_REQ    3'h4
`define CIW_FLAG_RST        15'h0000
`define CIW_ENABLE_RST      8'h00
`define CIW_CFG2_RST        16'h0000

// timing
`define CIW_CLK_NS          10
`define CIW_FILT_NS         50
`define CIW_FILT_CYC        ((`CIW_FILT_NS + `CIW_CLK_NS - 1) / `CIW_CLK_NS)
`define CIW_IDLE_BITS       4'hB

`endif

// ---- design/ciw_rx_cond.sv ----
`timescale 1ns/1ns
`include "ciw_regs.svh"

// two-flop synchroniser followed by an optional glitch filter
module ciw_rx_cond (
   // clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   // pin side
   input  wire logic pin_in,
   input  wire logic filter_en,
   // conditioned level
   output logic      level_q
);

   localparam logic [3:0] FILT_LAST = 4'(`CIW_FILT_CYC - 1);

   logic       s1_q;
   logic       s2_q;
   logic       level_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;

   always_comb begin
      level_d = level_q;
      cnt_d   = 4'h0;
      if (!filter_en) begin
         level_d = s2_q;
      end else if (s2_q != level_q) begin
         // a level must stand the whole filter time before it passes
         if (cnt_q == FILT_LAST) begin
            level_d = s2_q;
         end else begin
            cnt_d = cnt_q + 4'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_q    <= 1'b1;
         s2_q    <= 1'b1;
         level_q <= 1'b1;
         cnt_q   <= 4'h0;
      end else begin
         s1_q    <= pin_in;
         s2_q    <= s1_q;
         level_q <= level_d;
         cnt_q   <= cnt_d;
      end
   end

endmodule : ciw_rx_cond

// ---- design/ciw_top.sv ----
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ns
`include "ciw_regs.svh"

// Functional notes
// RULE1 - software keeps propagation plus phase one at least phase two
// RULE2 - software keeps phase two longer than the jump width
// RULE3 - software should put the sample point near 60 to 70 percent
// RULE4 - eight enable bits; a source interrupts only while enabled
// RULE5 - any error source sets the one shared error flag
// RULE6 - an interrupt stays pending while any of its flags is set
// RULE7 - clears are ignored while the condition holds, except counter thresholds
// RULE8 - software clears flags in its handler to acknowledge
// RULE9 - read-only code at control bits 3:1 shows top pending enabled interrupt
// RULE10 - a source shows in the code only if flag and enable set
// RULE11 - code order: error, tx0, tx1, tx2, rx0, rx1, wake-up, none
// RULE12 - accepted frame gives a one bit time stamp pulse after end of frame
// RULE13 - time-stamp enable routes receive pin to capture channel two
// RULE14 - config, disable and loopback return pins to port control
// RULE15 - active module drives transmit pin, overrides direction, reads receive pin
// RULE16 - software requests disable and waits for it before sleeping
// RULE17 - in sleep, bus activity sets the wake-up flag
// RULE18 - wake-up raises an interrupt only if its enable is set
// RULE19 - in disable mode the module wakes and receives the waking frame
// RULE20 - filter enable smooths receive input while module or processor sleeps
// RULE21 - after wake, wait 11 recessive bits before bus traffic
// RULE22 - stop-in-idle decides whether idle halts the module like sleep
// RULE23 - software keeps the jump width between 1 and 4 quanta
// RULE24 - one interrupt output while any flag and its enable are set
// RULE25 - pending code is combinational from the current flags and enables
module ciw_top
   import ciw_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // apb slave
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // events and conditions from the protocol engine
   input  wire logic [4:0]  src_event,
   input  wire logic [4:0]  src_hold,
   input  wire logic [6:0]  err_event,
   input  wire logic [6:0]  err_hold,
   input  wire logic        invalid_event,
   input  wire logic        frame_valid,
   input  wire logic        bit_tick,
   input  wire logic        can_tx_bit,
   // processor power state
   input  wire logic        cpu_sleep,
   input  wire logic        cpu_idle,
   // port i/o function
   input  wire logic        port_tx_out,
   input  wire logic        port_direction_bits,
   // pins
   input  wire logic        can_receive_pin,
   input  wire logic        capture_pin,
   output logic             can_transmit_pin,
   output logic             can_transmit_pin_oe,
   // to the engine, the timer and the processor
   output logic             can_rx_bit,
   output logic             bus_enable,
   output logic             capture_channel_two,
   output logic             timestamp_pulse,
   output logic             module_irq,
   output logic             cpu_wake
);

   // control and status state
   logic                     timestamp_enable_q, timestamp_enable_d;
   logic                     stop_in_idle_q, stop_in_idle_d;
   logic [2:0]               mode_request_field_q, mode_request_field_d;
   ciw_mode_type             current_mode_field_q, current_mode_field_d;
   logic [`CIW_FLAG_W-1:0]   irq_flag_reg_q, irq_flag_reg_d;
   logic [`CIW_MAIN_W-1:0]   irq_enable_reg_q, irq_enable_reg_d;
   logic [15:0]              timing_config_two_reg_q, timing_config_two_reg_d;
   ciw_wake_state_type       state_q, state_d;
   logic [3:0]               idle_cnt_q, idle_cnt_d;
   logic                     rx_prev_q;
   logic [31:0]              prdata_d;
   logic                     pready_d, pslverr_d;
   logic                     tx_pin_d, tx_oe_d, bus_en_d, cap_d, ts_d, irq_d, wake_d;

   // combinational helpers
   logic                     rx_lvl, cap_lvl;
   logic                     access, wr;
   logic                     halt, pins_owned, filt_on, wake_evt;
   logic [2:0]               pending_irq_code;
   logic [`CIW_MAIN_W-1:0]   active;
   logic [`CIW_FLAG_W-1:0]   set_vec, hold_vec, clr_vec;

   ciw_rx_cond u_rx_cond (
      .clk       (clk),
      .arst_n    (arst_n),
      .pin_in    (can_receive_pin),
      .filter_en (filt_on),
      .level_q   (rx_lvl)
   );

   ciw_rx_cond u_cap_cond (
      .clk       (clk),
      .arst_n    (arst_n),
      .pin_in    (capture_pin),
      .filter_en (1'b0),
      .level_q   (cap_lvl)
   );

   // pready is registered, so every access phase lasts exactly one cycle
   assign access = psel & penable & pready;
   assign wr     = access & pwrite;

   assign halt       = cpu_sleep | (cpu_idle & stop_in_idle_q); // RULE22
   assign pins_owned = (current_mode_field_q != MODE_CONFIG) &&
                       (current_mode_field_q != MODE_DISABLE) &&
                       (current_mode_field_q != MODE_LOOPBACK); // RULE14
   assign filt_on    = timing_config_two_reg_q[`CIW_CFG2_WAKE_GLITCH_FILTER_ENABLE_BIT] &
                       (halt | (current_mode_field_q == MODE_DISABLE)); // RULE20
   assign wake_evt   = (state_q == ST_HALT || current_mode_field_q == MODE_DISABLE) &
                       rx_prev_q & ~rx_lvl; // RULE17

   assign active = irq_flag_reg_q[`CIW_MAIN_W-1:0] & irq_enable_reg_q; // RULE4 RULE10

   // priority encoder; read back live so a handler sees the current top source
   always_comb begin
      if (active[`CIW_ERR_BIT]) begin // RULE9 RULE11 RULE25
         pending_irq_code = 3'h1;
      end else if (active[`CIW_TX0_BIT]) begin
         pending_irq_code = 3'h4;
      end else if (active[`CIW_TX1_BIT]) begin
         pending_irq_code = 3'h3;
      end else if (active[`CIW_TX2_BIT]) begin
         pending_irq_code = 3'h2;
      end else if (active[`CIW_RX0_BIT]) begin
         pending_irq_code = 3'h6;
      end else if (active[`CIW_RX1_BIT]) begin
         pending_irq_code = 3'h5;
      end else if (active[`CIW_WAK_BIT]) begin
         pending_irq_code = 3'h7;
      end else begin
         pending_irq_code = 3'h0;
      end
   end

   // flags: set wins over clear; a clear only lands where nothing holds the bit
   always_comb begin
      set_vec  = {err_event, invalid_event, wake_evt, |err_event, src_event}; // RULE5 RULE17
      hold_vec = {err_hold & ~`CIW_ESRC_EXEMPT, 1'b0, 1'b0, 1'b0, src_hold}; // RULE7
      clr_vec  = 15'h0000;
      if (wr && paddr == `CIW_FLAG_OFS) begin
         clr_vec = pwdata[`CIW_FLAG_W-1:0];
      end
      irq_flag_reg_d = set_vec | (irq_flag_reg_q & ~(clr_vec & ~hold_vec)); // RULE7
      // held by the sources that survive this cycle, so one write may clear a source and the shared flag
      irq_flag_reg_d[`CIW_ERR_BIT] = irq_flag_reg_d[`CIW_ERR_BIT] | (|irq_flag_reg_d[`CIW_FLAG_W-1:`CIW_ESRC_LO]); // RULE6
   end

   // register writes
   always_comb begin
      timestamp_enable_d      = timestamp_enable_q;
      stop_in_idle_d          = stop_in_idle_q;
      mode_request_field_d    = mode_request_field_q;
      irq_enable_reg_d        = irq_enable_reg_q;
      timing_config_two_reg_d = timing_config_two_reg_q;
      if (wr && paddr == `CIW_CTRL_OFS) begin
         timestamp_enable_d   = pwdata[`CIW_CTRL_TIMESTAMP_ENABLE_BIT];
         stop_in_idle_d       = pwdata[`CIW_CTRL_SIDL_BIT];
         mode_request_field_d = pwdata[`CIW_CTRL_REQ_HI:`CIW_CTRL_REQ_LO];
      end else if (wr && paddr == `CIW_ENABLE_OFS) begin
         irq_enable_reg_d = pwdata[`CIW_MAIN_W-1:0]; // RULE4
      end else if (wr && paddr == `CIW_CFG2_OFS) begin
         timing_config_two_reg_d = pwdata[15:0] & `CIW_CFG2_MASK;
      end
   end

   // apb read data captured in the setup cycle
   always_comb begin
      pready_d  = psel & ~penable;
      pslverr_d = 1'b0;
      prdata_d  = 32'h0000_0000;
      if (paddr == `CIW_CTRL_OFS) begin
         prdata_d[`CIW_CTRL_TIMESTAMP_ENABLE_BIT]               = timestamp_enable_q;
         prdata_d[`CIW_CTRL_SIDL_BIT]                 = stop_in_idle_q;
         prdata_d[`CIW_CTRL_REQ_HI:`CIW_CTRL_REQ_LO]   = mode_request_field_q;
         prdata_d[`CIW_CTRL_CUR_HI:`CIW_CTRL_CUR_LO]   = current_mode_field_q;
         prdata_d[`CIW_CTRL_CODE_HI:`CIW_CTRL_CODE_LO] = pending_irq_code; // RULE9
      end else if (paddr == `CIW_FLAG_OFS) begin
         prdata_d[`CIW_FLAG_W-1:0] = irq_flag_reg_q;
      end else if (paddr == `CIW_ENABLE_OFS) begin
         prdata_d[`CIW_MAIN_W-1:0] = irq_enable_reg_q;
      end else if (paddr == `CIW_CFG2_OFS) begin
         prdata_d[15:0] = timing_config_two_reg_q;
      end else begin
         pslverr_d = psel & ~penable;
      end
      if (!(psel & ~penable)) begin
         prdata_d = prdata;
      end
   end

   // wake state machine; mode follows its request except while halted or settling
   always_comb begin
      state_d              = state_q;
      idle_cnt_d           = idle_cnt_q;
      current_mode_field_d = current_mode_field_q;
      case (state_q)
         ST_RUN: begin
            current_mode_field_d = ciw_mode_type'(mode_request_field_q);
            if (halt) begin
               state_d = ST_HALT;
            end
         end
         ST_HALT: begin
            // stays here without an enabled wake-up until the processor resumes
            idle_cnt_d = 4'h0;
            if (!halt) begin
               state_d = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            if (halt) begin
               state_d = ST_HALT;
            end else if (mode_request_field_q == 3'(MODE_DISABLE)) begin
               idle_cnt_d = 4'h0;
            end else if (bit_tick) begin
               if (!rx_lvl) begin
                  idle_cnt_d = 4'h0;
               end else if (idle_cnt_q == `CIW_IDLE_BITS - 4'h1) begin // RULE21
                  state_d              = ST_RUN;
                  current_mode_field_d = ciw_mode_type'(mode_request_field_q);
               end else begin
                  idle_cnt_d = idle_cnt_q + 4'h1;
               end
            end
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
   end

   // outputs
   always_comb begin
      tx_pin_d = pins_owned ? can_tx_bit : port_tx_out; // RULE14 RULE15
      tx_oe_d  = pins_owned ? 1'b1 : ~port_direction_bits; // RULE15
      bus_en_d = (state_q == ST_RUN) &&
                 (pins_owned || current_mode_field_q == MODE_DISABLE); // RULE19 RULE21
      cap_d    = timestamp_enable_q ? rx_lvl : cap_lvl; // RULE13
      ts_d     = frame_valid | (timestamp_pulse & ~bit_tick); // RULE12
      irq_d    = |active; // RULE24
      wake_d   = halt & irq_flag_reg_q[`CIW_WAK_BIT] & irq_enable_reg_q[`CIW_WAK_BIT]; // RULE18
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         timestamp_enable_q      <= 1'b0;
         stop_in_idle_q          <= 1'b0;
         mode_request_field_q    <= `CIW_CTRL_RST_REQ;
         current_mode_field_q    <= MODE_CONFIG;
         irq_flag_reg_q          <= `CIW_FLAG_RST;
         irq_enable_reg_q        <= `CIW_ENABLE_RST;
         timing_config_two_reg_q <= `CIW_CFG2_RST;
         state_q                 <= ST_RUN;
         idle_cnt_q              <= 4'h0;
         rx_prev_q               <= 1'b1;
         prdata                  <= 32'h0000_0000;
         pready                  <= 1'b0;
         pslverr                 <= 1'b0;
         can_transmit_pin        <= 1'b1;
         can_transmit_pin_oe     <= 1'b0;
         can_rx_bit              <= 1'b1;
         bus_enable              <= 1'b0;
         capture_channel_two     <= 1'b1;
         timestamp_pulse         <= 1'b0;
         module_irq              <= 1'b0;
         cpu_wake                <= 1'b0;
      end else begin
         timestamp_enable_q      <= timestamp_enable_d;
         stop_in_idle_q          <= stop_in_idle_d;
         mode_request_field_q    <= mode_request_field_d;
         current_mode_field_q    <= current_mode_field_d;
         irq_flag_reg_q          <= irq_flag_reg_d;
         irq_enable_reg_q        <= irq_enable_reg_d;
         timing_config_two_reg_q <= timing_config_two_reg_d;
         state_q                 <= state_d;
         idle_cnt_q              <= idle_cnt_d;
         rx_prev_q               <= rx_lvl;
         prdata                  <= prdata_d;
         pready                  <= pready_d;
         pslverr                 <= pslverr_d;
         can_transmit_pin        <= tx_pin_d;
         can_transmit_pin_oe     <= tx_oe_d;
         can_rx_bit              <= rx_lvl;
         bus_enable              <= bus_en_d;
         capture_channel_two     <= cap_d;
         timestamp_pulse         <= ts_d;
         module_irq              <= irq_d;
         cpu_wake                <= wake_d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_err_shared: assert property ((|err_event) |=> irq_flag_reg_q[`CIW_ERR_BIT]) // RULE5
      else $error("error event did not set shared error flag");
   a_err_pending: assert property ((|irq_flag_reg_q[`CIW_FLAG_W-1:`CIW_ESRC_LO]) |-> irq_flag_reg_q[`CIW_ERR_BIT]) // RULE6
      else $error("error flag low while an error source is set");
   a_hold_blocks: assert property ((src_hold[0] && irq_flag_reg_q[0]) |=> irq_flag_reg_q[0]) // RULE7
      else $error("held flag was cleared");
   a_exempt_clear: assert property ((wr && paddr == `CIW_FLAG_OFS && pwdata[14] && !err_event[6])
                                    |=> !irq_flag_reg_q[14]) // RULE7
      else $error("threshold flag did not clear on request");
   a_code_error: assert property (active[`CIW_ERR_BIT] |-> pending_irq_code == 3'h1) // RULE11
      else $error("error not shown first in pending code");
   a_code_gated: assert property ((pending_irq_code == 3'h7) |->
                                  (active[6:0] == 7'h40)) // RULE10
      else $error("wake code shown without sole enabled wake flag");
   a_irq_follow: assert property ((active != 8'h00) |=> module_irq) // RULE24
      else $error("interrupt output missed an enabled flag");
   a_ts_pulse: assert property ((frame_valid && !bit_tick) ##1 !bit_tick |-> timestamp_pulse) // RULE12
      else $error("time stamp pulse ended before a bit time");
   a_pin_port: assert property (!pins_owned |=> can_transmit_pin_oe == !$past(port_direction_bits)) // RULE14
      else $error("pin not returned to port control");
   a_pin_can: assert property (pins_owned |=> can_transmit_pin_oe) // RULE15
      else $error("transmit pin not driven while active");
   a_wake_req: assert property (cpu_wake |-> $past(irq_enable_reg_q[`CIW_WAK_BIT])) // RULE18
      else $error("wake request without wake enable");
   a_settle_quiet: assert property ((state_q == ST_SETTLE) |=> !bus_enable) // RULE21
      else $error("bus enabled before recessive idle seen");

endmodule : ciw_top

// ---- verification/ciw_xcvr.sv ----
`timescale 1ns/1ns

// bus transceiver model: wired-and of our driver and the other nodes
module ciw_xcvr (
   // controller transmit pin
   input  wire logic txd,
   input  wire logic txd_oe,
   // another node driving dominant
   input  wire logic other_dom,
   // receive pin
   output logic      rxd
);
   // a released pin floats recessive through the termination, never to the last value
   assign rxd = ~other_dom & (txd_oe ? txd : 1'b1);
endmodule : ciw_xcvr

// ---- verification/tb.sv ----
`timescale 1ns/1ns

module tb;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, er;
   logic [4:0]  src_event = 5'h0, src_hold = 5'h0;
   logic [6:0]  err_event = 7'h0, err_hold = 7'h0;
   logic        invalid_event = 1'b0, frame_valid = 1'b0, bit_tick = 1'b0, can_tx_bit = 1'b1;
   logic        cpu_sleep = 1'b0, cpu_idle = 1'b0, port_tx_out = 1'b0, port_direction_bits = 1'b1;
   logic        capture_pin = 1'b0, dom = 1'b0;
   logic        rx, txp, txoe, can_rx_bit, bus_enable, cap2, tsp, module_irq, cpu_wake;
   int          fail_count = 0, cmp_count = 0, cyc = 0, tk = 0;
   logic [31:0] clr [6] = '{32'h1A0, 32'h4, 32'h8, 32'h10, 32'h1, 32'h2};
   logic [2:0]  cd [6]  = '{3'h4, 3'h3, 3'h2, 3'h6, 3'h5, 3'h0};

   ciw_top dut (.clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_event(src_event),
      .src_hold(src_hold), .err_event(err_event), .err_hold(err_hold), .invalid_event(invalid_event),
      .frame_valid(frame_valid), .bit_tick(bit_tick), .can_tx_bit(can_tx_bit), .cpu_sleep(cpu_sleep),
      .cpu_idle(cpu_idle), .port_tx_out(port_tx_out), .port_direction_bits(port_direction_bits),
      .can_receive_pin(rx), .capture_pin(capture_pin), .can_transmit_pin(txp), .can_transmit_pin_oe(txoe),
      .can_rx_bit(can_rx_bit), .bus_enable(bus_enable), .capture_channel_two(cap2),
      .timestamp_pulse(tsp), .module_irq(module_irq), .cpu_wake(cpu_wake));

   ciw_xcvr xcvr (.txd(txp), .txd_oe(txoe), .other_dom(dom), .rxd(rx));

   always #5 clk = ~clk;

   // bit boundary every 8 clocks keeps the settle wait short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      bit_tick <= (cyc % 8 == 7);
      if (cyc == 6000) begin
         fail_count++;
         results();
      end
   end

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdc

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt

   task automatic results;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results

   initial begin
      wt(16);
      arst_n <= 1'b1;
      wt(4);
      rdc(12'h000, 32'h0480);
      rdc(12'h004, 32'h0);
      rdc(12'h008, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, er}, 32'h1);
      apb(1'b1, 12'h00C, 32'hFFFFFFFF);
      rdc(12'h00C, 32'h47FF);
      // prop 2, phase one 7, phase two 6 quanta: sample point near 62 percent, room for jump width 1 to 4
      apb(1'b1, 12'h00C, 32'h4531);
      rdc(12'h00C, 32'h4531);
      $display("end registers");
      src_event <= 5'h04;
      @(posedge clk);
      src_event <= 5'h00;
      wt(3);
      chk({31'h0, module_irq}, 32'h0);
      rdc(12'h000, 32'h0480);
      apb(1'b1, 12'h004, 32'h4);
      apb(1'b1, 12'h008, 32'h7F);
      src_event <= 5'h1F;
      err_event <= 7'h01;
      invalid_event <= 1'b1;
      @(posedge clk);
      src_event <= 5'h00;
      err_event <= 7'h00;
      invalid_event <= 1'b0;
      wt(3);
      chk({31'h0, module_irq}, 32'h1);
      rdc(12'h000, 32'h0482);
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, 12'h004, clr[i]);
         rdc(12'h000, 32'h0480 | {cd[i], 1'b0});
      end
      wt(3);
      chk({31'h0, module_irq}, 32'h0);
      $display("end priority");
      src_hold <= 5'h01;
      err_hold <= 7'h05;
      src_event <= 5'h01;
      err_event <= 7'h05;
      @(posedge clk);
      src_event <= 5'h00;
      err_event <= 7'h00;
      wt(2);
      rdc(12'h004, 32'h0521);
      apb(1'b1, 12'h004, 32'h0521);
      rdc(12'h004, 32'h0121);
      chk({31'h0, module_irq}, 32'h1);
      src_hold <= 5'h00;
      err_hold <= 7'h00;
      apb(1'b1, 12'h004, 32'h0121);
      rdc(12'h004, 32'h0);
      $display("end hold");
      port_direction_bits <= 1'b0;
      wt(3);
      chk({30'h0, txoe, txp}, 32'h2);
      port_direction_bits <= 1'b1;
      apb(1'b1, 12'h000, 32'h0);
      wt(3);
      chk({30'h0, txoe, txp}, 32'h3);
      can_tx_bit <= 1'b0;
      wt(2);
      chk({31'h0, txp}, 32'h0);
      can_tx_bit <= 1'b1;
      dom <= 1'b1;
      wt(6);
      chk({31'h0, can_rx_bit}, 32'h0);
      dom <= 1'b0;
      wt(6);
      chk({31'h0, can_rx_bit}, 32'h1);
      apb(1'b1, 12'h000, 32'h0200);
      wt(3);
      chk({31'h0, txoe}, 32'h0);
      $display("end pins");
      apb(1'b1, 12'h008, 32'h40);
      apb(1'b1, 12'h000, 32'h0100);
      rdc(12'h000, 32'h0120);
      chk({31'h0, bus_enable}, 32'h1);
      cpu_sleep <= 1'b1;
      wt(3);
      dom <= 1'b1;
      wt(10);
      dom <= 1'b0;
      wt(8);
      rdc(12'h004, 32'h40);
      chk({31'h0, cpu_wake}, 32'h1);
      rdc(12'h000, 32'h012E);
      apb(1'b1, 12'h008, 32'h0);
      wt(3);
      chk({31'h0, cpu_wake}, 32'h0);
      apb(1'b1, 12'h004, 32'h40);
      cpu_sleep <= 1'b0;
      apb(1'b1, 12'h000, 32'h0);
      chk({31'h0, bus_enable}, 32'h0);
      tk = 0;
      while (bus_enable !== 1'b1 && tk < 40) begin
         @(posedge clk);
         if (bit_tick === 1'b1) tk++;
      end
      chk({31'h0, (tk >= 10 && tk <= 12)}, 32'h1);
      cpu_idle <= 1'b1;
      dom <= 1'b1;
      wt(10);
      dom <= 1'b0;
      wt(8);
      rdc(12'h004, 32'h0);
      cpu_idle <= 1'b0;
      $display("end wake");
      apb(1'b1, 12'h000, 32'h8000);
      dom <= 1'b1;
      wt(6);
      chk({31'h0, cap2}, 32'h0);
      dom <= 1'b0;
      wt(6);
      chk({31'h0, cap2}, 32'h1);
      apb(1'b1, 12'h000, 32'h0);
      wt(4);
      chk({31'h0, cap2}, 32'h0);
      while (bit_tick !== 1'b1) @(posedge clk);
      frame_valid <= 1'b1;
      @(posedge clk);
      frame_valid <= 1'b0;
      wt(2);
      chk({31'h0, tsp}, 32'h1);
      wt(10);
      chk({31'h0, tsp}, 32'h0);
      $display("end timestamp");
      results();
   end
endmodule : tb
